// ---- src/pmcs_pkg.sv ----
package pmcs_pkg;
	typedef enum logic [1:0] {
		PMCS_MODE_SLEEP,
		PMCS_MODE_DSTOP,
		PMCS_MODE_STANDBY,
		PMCS_MODE_RSVD
	} pmcs_mode_type;

	typedef enum logic [1:0] {
		PMCS_CLK_OSC_DIV,
		PMCS_CLK_XTAL,
		PMCS_CLK_PLL_XTAL,
		PMCS_CLK_PLL_OSC
	} pmcs_clk_type;

	// Voltage codes: 0 is 1.2 V
	typedef enum logic [1:0] {
		PMCS_V1P2,
		PMCS_V1P3,
		PMCS_V1P1,
		PMCS_V1P0
	} pmcs_volt_type;

	typedef enum logic [1:0] {
		PMCS_REG_NORMAL,
		PMCS_REG_LOWPWR,
		PMCS_REG_OFF
	} pmcs_reg_type;

	typedef enum logic [1:0] {
		PMCS_BOOT_FLASH,
		PMCS_BOOT_CODE,
		PMCS_BOOT_SRAM
	} pmcs_boot_type;
endpackage : pmcs_pkg

// ---- src/pmcs_regs.svh ----
`ifndef PMCS_REGS_SVH
`define PMCS_REGS_SVH

// Register byte offsets
`define PMCS_CTRL_OFF 12'h000
`define PMCS_CLK_OFF 12'h004
`define PMCS_STAT_OFF 12'h008
`define PMCS_IRQ_ST_OFF 12'h00c
`define PMCS_IRQ_MSK_OFF 12'h010
`define PMCS_BOOT_OFF 12'h014

// Control fields
`define PMCS_CTRL_MODE_LSB 0
`define PMCS_CTRL_LPREG_BIT 2
`define PMCS_CTRL_VSEL_LSB 4
`define PMCS_CTRL_SVM_EN_BIT 8
`define PMCS_CTRL_SVM_FALL_BIT 9
`define PMCS_CTRL_SVM_RISE_BIT 10

// Clock select field
`define PMCS_CLK_SEL_LSB 0

// Interrupt status bits
`define PMCS_IRQ_SVM_BIT 0
`define PMCS_IRQ_XFAIL_BIT 1
`define PMCS_IRQ_WAKE_BIT 2

// Reset values
`define PMCS_CTRL_RST 32'h0000_0000
`define PMCS_CLK_RST 2'h0
`define PMCS_VSEL_RST 2'h0

// Internal fast oscillator divide for default clock
`define PMCS_OSC_DIV 6

// Edges for the boot pin filter to refill after any reset
`define PMCS_BOOT_FILL 3'h4
`endif

// ---- src/pmcs_top.sv ----
`timescale 1ns/1ps
`include "pmcs_regs.svh"
module pmcs_top
	import pmcs_pkg::*;
#(
	parameter int EVT_LINES = 16
) (
	input wire logic pclk, // APB clock
	input wire logic presetn, // APB reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [11:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error
	input wire logic cpu_wait_req, // Processor wait or sleep request
	input wire logic periph_irq, // Any peripheral interrupt or event
	input wire logic [EVT_LINES-1:0] event_pins, // External event pin lines
	input wire logic svm_below, // Supply monitor comparator, async
	input wire logic calendar_event, // Calendar alarm/wakeup/tamper/stamp
	input wire logic net_wake, // USB OTG or Ethernet MAC wakeup
	input wire logic wake_pin, // Standby wake pin, async
	input wire logic external_reset_pin_n, // Reset pin, async, low
	input wire logic watchdog_reset, // Independent watchdog reset
	input wire logic supply_low, // Low-voltage reset comparator, async
	input wire logic xtal_fail, // Crystal clock monitor failure, async
	input wire logic [1:0] boot_pins, // Boot source pins, async
	input wire logic bank2_cfg, // Stored config: boot from bank 2
	input wire logic wdog_run_cfg, // Stored config: watchdog in low power
	output logic cpu_clk_en, // Processor clock enable
	output logic core_clk_en, // Core domain clock enable
	output logic pll_en, // PLL enable
	output logic osc_en, // Internal fast oscillator enable
	output logic xtal_en, // External crystal enable
	output logic [1:0] sys_clk_sel, // System clock source
	output logic [2:0] osc_div, // Internal oscillator divide
	output logic [1:0] reg_mode, // Core regulator mode
	output logic [1:0] reg_vsel, // Core regulator voltage code
	output logic calendar_run, // Calendar timer and clocks run
	output logic wdog_run, // Watchdog clock run
	output logic sys_reset_n, // System reset, active low
	output logic [1:0] boot_src, // Boot source
	output logic boot_bank2, // Boot from flash bank 2
	output logic irq // Interrupt, level
);
	//--------------------------------------------------
	// Input synchronisers
	//--------------------------------------------------
	logic [2:0] svm_sync_reg, wake_sync_reg, rst_sync_reg;
	logic [2:0] low_sync_reg, xf_sync_reg;
	logic [1:0] bp_s1_reg, bp_s2_reg, bp_s3_reg;
	logic svm_lvl_reg, wake_lvl_reg, rstp_lvl_reg, low_lvl_reg, xf_lvl_reg;
	logic [1:0] bp_lvl_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			svm_sync_reg <= 3'h0;
			wake_sync_reg <= 3'h0;
			rst_sync_reg <= 3'h7;
			low_sync_reg <= 3'h0;
			xf_sync_reg <= 3'h0;
			bp_s1_reg <= 2'h0;
			bp_s2_reg <= 2'h0;
			bp_s3_reg <= 2'h0;
		end else begin
			svm_sync_reg <= {svm_sync_reg[1:0], svm_below};
			wake_sync_reg <= {wake_sync_reg[1:0], wake_pin};
			rst_sync_reg <= {rst_sync_reg[1:0], external_reset_pin_n};
			low_sync_reg <= {low_sync_reg[1:0], supply_low};
			xf_sync_reg <= {xf_sync_reg[1:0], xtal_fail};
			bp_s1_reg <= boot_pins;
			bp_s2_reg <= bp_s1_reg;
			bp_s3_reg <= bp_s2_reg;
		end
	end

	// A change counts once stages two and three agree
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			svm_lvl_reg <= 1'b0;
			wake_lvl_reg <= 1'b0;
			rstp_lvl_reg <= 1'b1;
			low_lvl_reg <= 1'b0;
			xf_lvl_reg <= 1'b0;
			bp_lvl_reg <= 2'h0;
		end else begin
			if (svm_sync_reg[1] == svm_sync_reg[2])
				svm_lvl_reg <= svm_sync_reg[2];
			if (wake_sync_reg[1] == wake_sync_reg[2])
				wake_lvl_reg <= wake_sync_reg[2];
			if (rst_sync_reg[1] == rst_sync_reg[2])
				rstp_lvl_reg <= rst_sync_reg[2];
			if (low_sync_reg[1] == low_sync_reg[2])
				low_lvl_reg <= low_sync_reg[2];
			if (xf_sync_reg[1] == xf_sync_reg[2])
				xf_lvl_reg <= xf_sync_reg[2];
			if (bp_s2_reg == bp_s3_reg)
				bp_lvl_reg <= bp_s3_reg;
		end
	end

	//--------------------------------------------------
	// Register bus
	//--------------------------------------------------
	logic [1:0] mode_sel_reg, vsel_reg, clk_sel_reg;
	logic lp_reg_cfg_reg, svm_en_reg, svm_fall_reg, svm_rise_reg;
	logic [2:0] irq_st_reg, irq_msk_reg;
	pmcs_mode_type mode_sel;
	pmcs_volt_type vsel;
	pmcs_clk_type clk_sel;
	wire wr_en = psel && penable && pwrite;
	wire hit_ctrl = paddr == `PMCS_CTRL_OFF;
	wire hit_clk = paddr == `PMCS_CLK_OFF;
	wire hit_stat = paddr == `PMCS_STAT_OFF;
	wire hit_ist = paddr == `PMCS_IRQ_ST_OFF;
	wire hit_imsk = paddr == `PMCS_IRQ_MSK_OFF;
	wire hit_boot = paddr == `PMCS_BOOT_OFF;
	wire hit_any = hit_ctrl | hit_clk | hit_stat | hit_ist | hit_imsk | hit_boot;
	assign mode_sel = pmcs_mode_type'(mode_sel_reg);
	assign vsel = pmcs_volt_type'(vsel_reg);
	assign clk_sel = pmcs_clk_type'(clk_sel_reg);
	assign pready = 1'b1;
	assign pslverr = psel && penable && !hit_any;

	//--------------------------------------------------
	// Power mode sequencer
	//--------------------------------------------------
	typedef enum logic [1:0] {
		PMCS_ST_RUN,
		PMCS_ST_SLEEP,
		PMCS_ST_DSTOP,
		PMCS_ST_STANDBY
	} pmcs_state_type;
	pmcs_state_type state_reg, state_next;
	logic wake_prev_reg;
	logic svm_prev_reg;
	logic boot_done_reg;
	logic [1:0] boot_src_reg;
	logic boot_bank2_reg;
	logic [2:0] boot_cnt_reg;

	wire ext_event = |event_pins || svm_lvl_reg || calendar_event || net_wake;
	wire wake_rise = wake_lvl_reg && !wake_prev_reg;
	wire stby_exit = wake_rise || calendar_event || watchdog_reset;
	wire sys_rst = low_lvl_reg || !rstp_lvl_reg || watchdog_reset;
	wire svm_fall = svm_en_reg && svm_lvl_reg && !svm_prev_reg;
	wire svm_rise = svm_en_reg && !svm_lvl_reg && svm_prev_reg;
	wire svm_evt = (svm_fall && svm_fall_reg) || (svm_rise && svm_rise_reg);
	wire xtal_used = clk_sel == PMCS_CLK_XTAL || clk_sel == PMCS_CLK_PLL_XTAL;
	wire xf_evt = xf_lvl_reg && xtal_used;
	wire wake_evt = state_reg != PMCS_ST_RUN && state_next == PMCS_ST_RUN;
	wire [2:0] irq_set = {wake_evt, xf_evt, svm_evt};

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			PMCS_ST_RUN: begin
				if (cpu_wait_req) begin
					case (mode_sel)
						PMCS_MODE_SLEEP: state_next = PMCS_ST_SLEEP;
						PMCS_MODE_DSTOP: state_next = PMCS_ST_DSTOP;
						PMCS_MODE_STANDBY: state_next = PMCS_ST_STANDBY;
						default: state_next = PMCS_ST_RUN;
					endcase
				end
			end
			PMCS_ST_SLEEP: if (periph_irq || ext_event) state_next = PMCS_ST_RUN;
			PMCS_ST_DSTOP: if (ext_event) state_next = PMCS_ST_RUN;
			PMCS_ST_STANDBY: if (stby_exit) state_next = PMCS_ST_RUN;
			default: state_next = PMCS_ST_RUN;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= PMCS_ST_RUN;
			wake_prev_reg <= 1'b0;
			svm_prev_reg <= 1'b0;
		end else if (sys_rst) begin
			state_reg <= PMCS_ST_RUN;
			wake_prev_reg <= wake_lvl_reg;
			svm_prev_reg <= svm_lvl_reg;
		end else begin
			state_reg <= state_next;
			wake_prev_reg <= wake_lvl_reg;
			svm_prev_reg <= svm_lvl_reg;
		end
	end

	// Standby loses core registers, so it clears config on exit
	wire stby_clear = state_reg == PMCS_ST_STANDBY && state_next == PMCS_ST_RUN;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_sel_reg <= 2'h0;
			lp_reg_cfg_reg <= 1'b0;
			vsel_reg <= `PMCS_VSEL_RST;
			svm_en_reg <= 1'b0;
			svm_fall_reg <= 1'b0;
			svm_rise_reg <= 1'b0;
			clk_sel_reg <= `PMCS_CLK_RST;
			irq_msk_reg <= 3'h0;
		end else if (sys_rst || stby_clear) begin
			mode_sel_reg <= 2'h0;
			lp_reg_cfg_reg <= 1'b0;
			vsel_reg <= `PMCS_VSEL_RST;
			svm_en_reg <= 1'b0;
			svm_fall_reg <= 1'b0;
			svm_rise_reg <= 1'b0;
			clk_sel_reg <= `PMCS_CLK_RST;
			irq_msk_reg <= 3'h0;
		end else begin
			if (wr_en && hit_ctrl) begin
				mode_sel_reg <= pwdata[`PMCS_CTRL_MODE_LSB +: 2];
				lp_reg_cfg_reg <= pwdata[`PMCS_CTRL_LPREG_BIT];
				vsel_reg <= pwdata[`PMCS_CTRL_VSEL_LSB +: 2];
				svm_en_reg <= pwdata[`PMCS_CTRL_SVM_EN_BIT];
				svm_fall_reg <= pwdata[`PMCS_CTRL_SVM_FALL_BIT];
				svm_rise_reg <= pwdata[`PMCS_CTRL_SVM_RISE_BIT];
			end
			if (xf_evt)
				clk_sel_reg <= `PMCS_CLK_RST;
			else if (wr_en && hit_clk)
				clk_sel_reg <= pwdata[`PMCS_CLK_SEL_LSB +: 2];
			if (wr_en && hit_imsk)
				irq_msk_reg <= pwdata[2:0];
		end
	end

	// Sticky status, set wins over write-one clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			irq_st_reg <= 3'h0;
		else if (sys_rst)
			irq_st_reg <= 3'h0;
		else if (wr_en && hit_ist)
			irq_st_reg <= (irq_st_reg & ~pwdata[2:0]) | irq_set;
		else
			irq_st_reg <= irq_st_reg | irq_set;
	end

	// boot source caught after reset release
	// Waits for the filter to refill, else its reset value is taken
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			boot_done_reg <= 1'b0;
			boot_cnt_reg <= 3'h0;
			boot_src_reg <= PMCS_BOOT_FLASH;
			boot_bank2_reg <= 1'b0;
		end else if (sys_rst || stby_clear) begin
			boot_done_reg <= 1'b0;
			boot_cnt_reg <= 3'h0;
		end else if (boot_cnt_reg != `PMCS_BOOT_FILL) begin
			boot_cnt_reg <= 3'(boot_cnt_reg + 3'h1);
		end else if (!boot_done_reg) begin
			boot_done_reg <= 1'b1;
			boot_src_reg <= (bp_lvl_reg == 2'h3) ? PMCS_BOOT_FLASH : bp_lvl_reg;
			boot_bank2_reg <= bank2_cfg;
		end
	end

	//--------------------------------------------------
	// Outputs
	//--------------------------------------------------
	wire st_run = state_reg == PMCS_ST_RUN;
	wire st_dstop = state_reg == PMCS_ST_DSTOP;
	wire st_stby = state_reg == PMCS_ST_STANDBY;
	wire low_deep = st_dstop || st_stby;
	assign cpu_clk_en = st_run && !sys_rst && boot_done_reg;
	assign core_clk_en = !low_deep;
	assign pll_en = !low_deep && clk_sel_reg[1];
	assign osc_en = !low_deep;
	assign xtal_en = !low_deep && xtal_used && !xf_lvl_reg;
	assign sys_clk_sel = clk_sel_reg;
	assign osc_div = 3'(`PMCS_OSC_DIV);
	assign reg_mode = st_stby ? PMCS_REG_OFF :
		(st_dstop && lp_reg_cfg_reg) ? PMCS_REG_LOWPWR : PMCS_REG_NORMAL;
	assign reg_vsel = vsel;
	assign calendar_run = 1'b1;
	assign wdog_run = !low_deep || wdog_run_cfg;
	assign sys_reset_n = !sys_rst;
	assign boot_src = boot_src_reg;
	assign boot_bank2 = boot_bank2_reg;
	assign irq = |(irq_st_reg & irq_msk_reg);

	wire [31:0] rd_ctrl = {21'h0, svm_rise_reg, svm_fall_reg, svm_en_reg,
		2'h0, vsel_reg, 1'b0, lp_reg_cfg_reg, mode_sel_reg};
	wire [31:0] rd_stat = {24'h0, xf_lvl_reg, svm_lvl_reg, 4'h0, state_reg};
	wire [31:0] rd_boot = {29'h0, boot_bank2_reg, boot_src_reg};
	wire [31:0] rd_mux = hit_ctrl ? rd_ctrl :
		hit_clk ? {30'h0, clk_sel_reg} :
		hit_stat ? rd_stat :
		hit_ist ? {29'h0, irq_st_reg} :
		hit_imsk ? {29'h0, irq_msk_reg} :
		hit_boot ? rd_boot : 32'h0;
	assign prdata = (psel && !pwrite) ? rd_mux : 32'h0;
endmodule : pmcs_top

// ---- verif/pmcs_checker.sv ----
`timescale 1ns/1ps
module pmcs_checker
	import pmcs_pkg::*;
#(
	parameter int EVT_LINES = 16
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic cpu_wait_req,
	input wire logic periph_irq,
	input wire logic [EVT_LINES-1:0] event_pins,
	input wire logic wake_pin,
	input wire logic supply_low,
	input wire logic xtal_fail,
	input wire logic cpu_clk_en,
	input wire logic core_clk_en,
	input wire logic pll_en,
	input wire logic osc_en,
	input wire logic xtal_en,
	input wire logic [1:0] sys_clk_sel,
	input wire logic [1:0] reg_mode,
	input wire logic sys_reset_n
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ----------
	// Mode and clock checks
	// ----------
	// Synchronised inputs need about four edges
	sequence s_up;
		##[1:8] core_clk_en;
	endsequence
	sequence s_deep;
		sys_reset_n && !core_clk_en && reg_mode != 2'h2;
	endsequence
	property p_gate;
		sys_reset_n && !core_clk_en |-> !(pll_en || osc_en || xtal_en);
	endproperty
	a_gate: assert property (p_gate) else $error("source on");
	property p_mode;
		reg_mode != 2'h0 |-> !core_clk_en && reg_mode != 2'h3;
	endproperty
	a_mode: assert property (p_mode) else $error("bad reg mode");
	property p_wake;
		s_deep ##0 (event_pins != '0) |-> s_up;
	endproperty
	a_wake: assert property (p_wake) else $error("no deep wake");
	property p_stby;
		reg_mode == 2'h2 && $rose(wake_pin) |-> ##[1:10] reg_mode == 2'h0;
	endproperty
	a_stby: assert property (p_stby) else $error("no standby exit");
	property p_sleep;
		sys_reset_n && core_clk_en && !cpu_clk_en && periph_irq |->
			##[1:8] cpu_clk_en;
	endproperty
	a_sleep: assert property (p_sleep) else $error("no sleep wake");
	property p_stop;
		$fell(cpu_clk_en) && sys_reset_n |-> $past(cpu_wait_req);
	endproperty
	a_stop: assert property (p_stop) else $error("unasked stop");
	property p_low;
		supply_low [*6] |-> !sys_reset_n;
	endproperty
	a_low: assert property (p_low) else $error("no supply reset");
	property p_xfail;
		$rose(xtal_fail) && (sys_clk_sel[0] ^ sys_clk_sel[1]) |->
			##[1:8] sys_clk_sel == 2'h0 && !xtal_en;
	endproperty
	a_xfail: assert property (p_xfail) else $error("no fallback");
endmodule : pmcs_checker

bind pmcs_top pmcs_checker #(.EVT_LINES(EVT_LINES)) i_chk (.*);

// ---- verif/pmcs_core_model.sv ----
`timescale 1ns/1ps
module pmcs_core_model (
	input wire logic pclk, // Bus clock
	input wire logic presetn, // Reset, active low
	input wire logic go, // Execute a wait instruction
	input wire logic cpu_clk_en, // Processor clock enable
	output logic cpu_wait_req // Wait or sleep request
);
	// request until clock stops
	// Dropped while halted, else a wake would re-enter at once
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cpu_wait_req <= 1'h0;
		end else if (go && cpu_clk_en) begin
			cpu_wait_req <= 1'h1;
		end else if (!cpu_clk_en) begin
			cpu_wait_req <= 1'h0;
		end
	end
endmodule : pmcs_core_model

// ---- verif/pmcs_top_tb.sv ----
`timescale 1ns/1ps
module pmcs_top_tb
	import pmcs_pkg::*;
;
	typedef struct packed {
		logic [11:0] a;
		logic [31:0] d, e;
		logic err;
	} pmcs_row_type;
	localparam pmcs_row_type rows [8] = '{
		'{12'h000, 32'hffff_ffff, 32'h737, 1'h0},
		'{12'h000, 32'h10, 32'h10, 1'h0},
		'{12'h000, 32'h20, 32'h20, 1'h0},
		'{12'h004, 32'h3, 32'h3, 1'h0},
		'{12'h004, 32'h0, 32'h0, 1'h0},
		'{12'h008, 32'hffff_ffff, 32'h0, 1'h0},
		'{12'h010, 32'hffff_ffff, 32'h7, 1'h0},
		'{12'h018, 32'h5, 32'h0, 1'h1}
	};
	logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0;
	logic pwrite = 1'h0, go = 1'h0, periph_irq = 1'h0, svm_below = 1'h0;
	logic wake_pin = 1'h0, watchdog_reset = 1'h0, supply_low = 1'h0;
	logic xtal_fail = 1'h0, bank2_cfg = 1'h1, wdog_run_cfg = 1'h0;
	logic calendar_event = 1'h0, net_wake = 1'h0, external_reset_pin_n = 1'h1;
	logic [1:0] boot_pins = 2'h2;
	logic [11:0] paddr = 12'h0;
	logic [15:0] event_pins = 16'h0;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, cpu_wait_req, cpu_clk_en, core_clk_en, pll_en;
	logic osc_en, xtal_en, calendar_run, wdog_run, sys_reset_n, boot_bank2;
	logic irq, er;
	logic [1:0] sys_clk_sel, reg_mode, reg_vsel, boot_src;
	logic [2:0] osc_div;
	int failures = 0, total_checks = 0;

	pmcs_top #(.EVT_LINES(16)) i_dut (.*);
	pmcs_core_model i_core (.pclk(pclk), .presetn(presetn), .go(go),
		.cpu_clk_en(cpu_clk_en), .cpu_wait_req(cpu_wait_req));

	// bus clock 100 MHz, under both caps
	initial begin
		forever #5 pclk = ~pclk;
	end
	// Whole run is a few hundred cycles
	initial begin
		#200000;
		failures++;
		conclude();
	end
	// ----------
	// Tasks
	// ----------
	task automatic chk(input string n, input logic [31:0] e, g);
		total_checks++;
		if (g !== e) begin
			failures++;
			$display("[ERR] %s exp %h got %h", n, e, g);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, d};
		@(posedge pclk);
		penable <= 1'h1;
		do @(posedge pclk); while (pready !== 1'h1);
		rd = prdata;
		er = pslverr;
		{psel, penable} <= 2'h0;
		#1;
	endtask : apb
	task automatic rdc(input string n, input logic [11:0] a, input logic [31:0] e);
		apb(1'h0, a, 32'h0);
		chk(n, e, rd);
	endtask : rdc
	// Synchronisers settle in about four edges
	task automatic sl;
		repeat (8) @(posedge pclk);
		#1;
	endtask : sl
	task automatic wup;
		for (int n = 0; n < 40 && cpu_clk_en !== 1'h1; n++) @(posedge pclk);
		#1;
	endtask : wup
	task automatic req;
		@(posedge pclk) go <= 1'h1;
		@(posedge pclk) go <= 1'h0;
		sl();
	endtask : req
	task automatic conclude;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : conclude
	// ----------
	// Main sequence
	// ----------
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'h1;
		wup();
		chk("cpu_clk_en", 1'h1, cpu_clk_en);
		chk("clk_sel", PMCS_CLK_OSC_DIV, sys_clk_sel);
		chk("osc_div", 3'h6, osc_div);
		chk("reg_mode", PMCS_REG_NORMAL, reg_mode);
		chk("vsel", PMCS_V1P2, reg_vsel);
		chk("boot", {1'h1, PMCS_BOOT_SRAM}, {boot_bank2, boot_src});
		rdc("boot", 12'h014, 32'h6);
		foreach (rows[i]) begin
			apb(1'h1, rows[i].a, rows[i].d);
			chk("pslverr", rows[i].err, er);
			rdc("reg", rows[i].a, rows[i].e);
			if (rows[i].a == 12'h0) chk("vsel", rows[i].e[5:4], reg_vsel);
		end
		req();
		chk("cpu_clk_en", 2'h2, {core_clk_en, cpu_clk_en});
		@(posedge pclk) periph_irq <= 1'h1;
		wup();
		@(posedge pclk) periph_irq <= 1'h0;
		chk("irq", 1'h1, irq);
		apb(1'h1, 12'h010, 32'h0);
		chk("irq", 1'h0, irq);
		apb(1'h1, 12'h00c, 32'h7);
		apb(1'h1, 12'h010, 32'h7);
		chk("irq", 1'h0, irq);
		for (int lp = 0; lp < 2; lp++) begin
			apb(1'h1, 12'h000, lp * 4 + 1);
			@(posedge pclk) wdog_run_cfg <= lp[0];
			req();
			chk("clks", 4'h0, {core_clk_en, pll_en, osc_en, xtal_en});
			chk("reg_mode", lp, reg_mode);
			chk("wdog", {1'h1, lp[0]}, {calendar_run, wdog_run});
			apb(1'h1, 12'h000, lp * 4 + 32'h31);
			chk("vsel", PMCS_V1P0, reg_vsel);
			@(posedge pclk) periph_irq <= 1'h1;
			sl();
			chk("core_clk_en", 1'h0, core_clk_en);
			@(posedge pclk) {periph_irq, event_pins} <= {1'h0, 16'h1 << 15 * lp};
			wup();
			@(posedge pclk) event_pins <= 16'h0;
			chk("woken", 3'h4, {core_clk_en, reg_mode});
		end
		for (int k = 0; k < 4; k++) begin
			apb(1'h1, 12'h000, 32'h2);
			req();
			chk("reg_mode", PMCS_REG_OFF, reg_mode);
			chk("clks", 4'h0, {core_clk_en, pll_en, osc_en, xtal_en});
			// Exit by wake pin, watchdog, calendar, then reset pin
			@(posedge pclk) begin
				{calendar_event, watchdog_reset, wake_pin} <= 3'h1 << k;
				external_reset_pin_n <= k != 3;
				boot_pins <= 2'(k);
			end
			sl();
			@(posedge pclk) begin
				{calendar_event, watchdog_reset, wake_pin} <= 3'h0;
				external_reset_pin_n <= 1'h1;
			end
			wup();
			chk("reg_mode", PMCS_REG_NORMAL, reg_mode);
			rdc("ctrl", 12'h000, 32'h0);
			chk("boot", {1'h1, k == 3 ? 2'h0 : 2'(k)}, {boot_bank2, boot_src});
		end
		apb(1'h1, 12'h010, 32'h2);
		for (int s = 1; s < 3; s++) begin
			apb(1'h1, 12'h004, s);
			chk("xtal_pll", {1'h1, s[1]}, {xtal_en, pll_en});
			@(posedge pclk) xtal_fail <= 1'h1;
			sl();
			chk("fallback", 4'h1, {sys_clk_sel, xtal_en, irq});
			@(posedge pclk) xtal_fail <= 1'h0;
			sl();
			apb(1'h1, 12'h00c, 32'h2);
			chk("irq", 1'h0, irq);
		end
		apb(1'h1, 12'h010, 32'h1);
		apb(1'h1, 12'h000, 32'h300);
		@(posedge pclk) svm_below <= 1'h1;
		sl();
		chk("irq", 1'h1, irq);
		rdc("stat", 12'h008, 32'h40);
		apb(1'h1, 12'h000, 32'h500);
		apb(1'h1, 12'h00c, 32'h1);
		chk("irq", 1'h0, irq);
		@(posedge pclk) svm_below <= 1'h0;
		sl();
		chk("irq", 1'h1, irq);
		@(posedge pclk) supply_low <= 1'h1;
		sl();
		chk("sys_reset_n", 1'h0, sys_reset_n);
		@(posedge pclk) supply_low <= 1'h0;
		wup();
		chk("sys_reset_n", 1'h1, sys_reset_n);
		conclude();
	end
endmodule : pmcs_top_tb
